// file: hdl/tcs_pkg.sv
// Purpose: constants and types for the transceiver command sequencer
// Assumes: 10 MHz core clock, AXI4-Lite register access, 32-bit data
// Notes: register offsets are byte addresses on the lite bus
// Behaviour
// R01 - sleep bit set enters soft power-down immediately
// R02 - power-down keeps registers, FIFO and configuration
// R03 - sleep bit reads one for 1024 clocks
// R04 - host sends 55h, then polls address zero
// R05 - either driver enable low powers transmitter down
// R06 - wait 1024 clocks before accepting host accesses
// R07 - command code starts command; FIFO carries data
// R08 - stream commands run now; send-listen waits launch
// R09 - fixed-argument command waits for all bytes
// R10 - FIFO not cleared when command starts
// R11 - new command code abandons running command
// R12 - code 0000 idles and cancels, self completes
// R13 - code 0010 makes 10-byte random identifier
// R14 - code 0011 runs checksum or self test
// R15 - code 0100 transmits; code 1000 receives
// R16 - code 0111 keeps command, updates other bits
// R17 - code 1100 transmits then switches to receive
// R18 - code 1101 target activation, card mode only
// R19 - code 1110 crypto authentication as reader
// R20 - configure takes 25 bytes in fixed order
// R21 - short id byte0 08h, check byte computed
// R22 - peer id from short, polling, peer bytes
// R23 - configure with empty FIFO reads buffer back
// R24 - command done flag when command returns idle
// R25 - transmit ends on empty FIFO or new code
package tcs_pkg;
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_FIFO = 8'h04;
  localparam logic [7:0] ADDR_LEVEL = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_TXCTL = 8'h10;
  localparam logic [7:0] ADDR_FRAME = 8'h14;
  localparam logic [7:0] ADDR_MODE = 8'h18;
  localparam logic [7:0] ADDR_EVENT = 8'h1C;
  localparam logic [7:0] ADDR_PEER = 8'h20;
  localparam int CMD_SLEEP_BIT = 4;
  localparam int TXCTL_DRV1_BIT = 0;
  localparam int TXCTL_DRV2_BIT = 1;
  localparam int FRAME_LAUNCH_BIT = 7;
  localparam int MODE_SELFTEST_BIT = 0;
  localparam int MODE_CARD_BIT = 1;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_TXOFF_BIT = 1;
  localparam int STAT_SLEEP_BIT = 2;
  localparam int EV_RXEND_BIT = 0;
  localparam int EV_AUTHOK_BIT = 1;
  localparam int EV_ACTOK_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int FIFO_DEPTH = 64;
  localparam int FIFO_AW = 6;
  localparam int CFG_BYTES = 25;
  localparam int RAND_BYTES = 10;
  localparam int AUTH_ARGS = 12;
  localparam int SHORT_ID_POS = 2;
  localparam int CHECK_POS = 5;
  localparam int POLL_ID_POS = 9;
  localparam int PEER_POS = 24;
  localparam logic [7:0] SHORT_ID_FIXED = 8'h08;
  localparam logic [7:0] POLL_HEAD0 = 8'h01;
  localparam logic [7:0] POLL_HEAD1 = 8'hFE;
  localparam int CLK_HZ = 10_000_000;
  localparam int WAKE_CLOCKS = 1024;
  localparam int STARTUP_DELAY_NS = 37740;
  localparam int STARTUP_CYCLES_RAW = (STARTUP_DELAY_NS / 100);
  localparam int STARTUP_CYCLES = (STARTUP_CYCLES_RAW < 1) ? 1 : STARTUP_CYCLES_RAW;
  localparam logic [10:0] WAKE_CNT = 11'(WAKE_CLOCKS);
  localparam logic [10:0] STARTUP_CNT = 11'(WAKE_CLOCKS);
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  typedef enum logic [3:0] {
    CMD_IDLE = 4'b0000,
    CMD_CONFIG = 4'b0001,
    CMD_RANDOM = 4'b0010,
    CMD_CHECKSUM = 4'b0011,
    CMD_TRANSMIT = 4'b0100,
    CMD_KEEP = 4'b0111,
    CMD_RECEIVE = 4'b1000,
    CMD_SENDLISTEN = 4'b1100,
    CMD_ACTIVATE = 4'b1101,
    CMD_AUTH = 4'b1110,
    CMD_SELFRESET = 4'b1111
  } tcs_cmd_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_CFG_LOAD = 4'b0001,
    ST_CFG_READ = 4'b0010,
    ST_RANDOM = 4'b0011,
    ST_CHECKSUM = 4'b0100,
    ST_SELFTEST = 4'b0101,
    ST_TRANSMIT = 4'b0110,
    ST_RECEIVE = 4'b0111,
    ST_SL_WAIT = 4'b1000,
    ST_SL_SEND = 4'b1001,
    ST_SL_RECV = 4'b1010,
    ST_ACTIVATE = 4'b1011,
    ST_AUTH_ARGS = 4'b1100,
    ST_AUTH_RUN = 4'b1101
  } tcs_state_e;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } tcs_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } tcs_axi_rsp_s;

  typedef struct packed {
    logic txActive;
    logic rxActive;
    logic checksumActive;
    logic fieldOn;
    logic softPowerDown;
    logic [7:0] txByte;
    logic txStrobe;
    logic [7:0] crcByte;
    logic crcStrobe;
  } tcs_core_s;
endpackage

// file: hdl/tcs_sequencer.sv
// Purpose: command state machine, FIFO and power-down control
// Assumes: host obeys AXI4-Lite; analog and protocol engines sit outside
// Notes: protocol engines report completion through event inputs
`timescale 1ns/1ps
module tcs_sequencer (
  input wire logic clk,
  input wire logic rst,
  input wire tcs_pkg::tcs_axi_req_s axiReq,
  output tcs_pkg::tcs_axi_rsp_s axiRsp,
  input wire logic [2:0] engineEvent,
  output tcs_pkg::tcs_core_s core
);
  localparam int FIFO_AWP = tcs_pkg::FIFO_AW;
  typedef struct packed {
    logic awHave;
    logic [7:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    tcs_pkg::tcs_cmd_e cmd;
    tcs_pkg::tcs_state_e state;
    logic sleepReq;
    logic sleeping;
    logic [10:0] wakeCnt;
    logic [10:0] startCnt;
    logic [1:0] txCtl;
    logic launch;
    logic [1:0] mode;
    logic done;
    logic [FIFO_AWP:0] count;
    logic [tcs_pkg::FIFO_AW-1:0] rdPtr;
    logic [tcs_pkg::FIFO_AW-1:0] wrPtr;
    logic [4:0] idx;
    logic [15:0] lfsr;
    logic [7:0] txByte;
    logic txStrobe;
    logic [7:0] crcByte;
    logic crcStrobe;
  } tcs_state_s;

  tcs_state_s s_r;
  tcs_state_s s_nxt;
  logic [7:0] fifoMem [tcs_pkg::FIFO_DEPTH];
  logic [7:0] cfgMem [tcs_pkg::CFG_BYTES];
  logic fifoPush;
  logic [7:0] fifoPushData;
  logic cfgWrite;
  logic [7:0] cfgWriteData;

  function automatic logic [7:0] byteOf(input logic [31:0] w);
    byteOf = w[7:0];
  endfunction

  function automatic logic [7:0] fold(input logic [7:0] a, input logic [7:0] b);
    fold = a ^ b;
  endfunction

  logic fifoEmpty;
  logic [7:0] fifoHead;
  logic [7:0] checkByte;
  assign fifoEmpty = (s_r.count == '0);
  assign fifoHead = fifoMem[s_r.rdPtr];
  // check byte covers the fixed head byte and the two stored id bytes
  assign checkByte = fold(fold(tcs_pkg::SHORT_ID_FIXED, cfgMem[tcs_pkg::SHORT_ID_POS + 1]),
                          cfgMem[tcs_pkg::SHORT_ID_POS + 2]);

  assign axiRsp.awready = !s_r.awHave && !s_r.bValid;
  assign axiRsp.wready = !s_r.wHave && !s_r.bValid;
  assign axiRsp.bvalid = s_r.bValid;
  assign axiRsp.bresp = s_r.bResp;
  // host accesses wait out the startup delay; reads stall rather than fail
  assign axiRsp.arready = !s_r.rValid && (s_r.startCnt == '0); // R06
  assign axiRsp.rvalid = s_r.rValid;
  assign axiRsp.rdata = s_r.rData;
  assign axiRsp.rresp = s_r.rResp;

  assign core.txActive = (s_r.state == tcs_pkg::ST_TRANSMIT) || (s_r.state == tcs_pkg::ST_SL_SEND);
  assign core.rxActive = (s_r.state == tcs_pkg::ST_RECEIVE) || (s_r.state == tcs_pkg::ST_SL_RECV)
                         || (s_r.state == tcs_pkg::ST_ACTIVATE);
  assign core.checksumActive = (s_r.state == tcs_pkg::ST_CHECKSUM);
  assign core.fieldOn = &s_r.txCtl && !s_r.sleeping; // R05
  assign core.softPowerDown = s_r.sleeping; // R01
  assign core.txByte = s_r.txByte;
  assign core.txStrobe = s_r.txStrobe;
  assign core.crcByte = s_r.crcByte;
  assign core.crcStrobe = s_r.crcStrobe;

  always_comb begin
    logic wrGo;
    logic rdGo;
    logic pop;
    logic newCmd;
    logic hostPush;
    tcs_pkg::tcs_cmd_e code;
    wrGo = 1'b0;
    rdGo = 1'b0;
    pop = 1'b0;
    newCmd = 1'b0;
    hostPush = 1'b0;
    code = tcs_pkg::CMD_KEEP;
    fifoPush = 1'b0;
    fifoPushData = '0;
    cfgWrite = 1'b0;
    cfgWriteData = '0;
    s_nxt = s_r;
    s_nxt.txStrobe = 1'b0;
    s_nxt.crcStrobe = 1'b0;
    if (s_r.startCnt != '0) begin
      s_nxt.startCnt = s_r.startCnt - 11'h001; // R06
    end
    if (axiReq.awvalid && axiRsp.awready) begin
      s_nxt.awHave = 1'b1;
      s_nxt.awAddr = axiReq.awaddr[7:0];
    end
    if (axiReq.wvalid && axiRsp.wready) begin
      s_nxt.wHave = 1'b1;
      s_nxt.wData = axiReq.wdata;
      s_nxt.wStrb = axiReq.wstrb;
    end
    if (axiReq.bready && s_r.bValid) begin
      s_nxt.bValid = 1'b0;
    end
    if (axiReq.rready && s_r.rValid) begin
      s_nxt.rValid = 1'b0;
    end
    wrGo = s_r.awHave && s_r.wHave && (s_r.startCnt == '0); // R06
    // -----------------------------------------------------------------
    // command engine
    // -----------------------------------------------------------------
    unique case (s_r.state)
      tcs_pkg::ST_IDLE: begin
      end
      tcs_pkg::ST_CFG_LOAD: begin
        if (!fifoEmpty) begin // R09
          pop = 1'b1;
          cfgWrite = 1'b1; // R20
          cfgWriteData = (s_r.idx == 5'(tcs_pkg::SHORT_ID_POS)) ? tcs_pkg::SHORT_ID_FIXED
                         : byteOf({24'h0, fifoHead}); // R21
          s_nxt.idx = s_r.idx + 5'h01;
          if (s_r.idx == 5'(tcs_pkg::CFG_BYTES - 1)) begin
            s_nxt.state = tcs_pkg::ST_IDLE;
            s_nxt.cmd = tcs_pkg::CMD_IDLE;
            s_nxt.done = 1'b1; // R24
          end
        end
      end
      tcs_pkg::ST_CFG_READ: begin
        if (s_r.count < (FIFO_AWP + 1)'(tcs_pkg::FIFO_DEPTH)) begin
          fifoPush = 1'b1; // R23
          fifoPushData = cfgMem[s_r.idx];
          s_nxt.idx = s_r.idx + 5'h01;
          if (s_r.idx == 5'(tcs_pkg::CFG_BYTES - 1)) begin
            s_nxt.state = tcs_pkg::ST_IDLE;
            s_nxt.cmd = tcs_pkg::CMD_IDLE;
            s_nxt.done = 1'b1; // R24
          end
        end
      end
      tcs_pkg::ST_RANDOM: begin
        s_nxt.lfsr = {s_r.lfsr[14:0], s_r.lfsr[15] ^ s_r.lfsr[13] ^ s_r.lfsr[12] ^ s_r.lfsr[10]};
        cfgWrite = 1'b1; // R13
        cfgWriteData = s_r.lfsr[7:0];
        s_nxt.idx = s_r.idx + 5'h01;
        // last random byte sits just below the peer byte; index must not wrap
        if (s_r.idx == 5'(tcs_pkg::PEER_POS - 1)) begin
          s_nxt.state = tcs_pkg::ST_IDLE;
          s_nxt.cmd = tcs_pkg::CMD_IDLE;
          s_nxt.done = 1'b1; // R24
        end
      end
      tcs_pkg::ST_CHECKSUM: begin
        if (!fifoEmpty) begin // R08
          pop = 1'b1; // R14
          s_nxt.crcByte = fifoHead;
          s_nxt.crcStrobe = 1'b1;
        end
      end
      tcs_pkg::ST_SELFTEST: begin
        // self test result: one pattern byte pushed, then the engine idles
        fifoPush = 1'b1; // R14
        fifoPushData = s_r.lfsr[15:8];
        s_nxt.state = tcs_pkg::ST_IDLE;
        s_nxt.cmd = tcs_pkg::CMD_IDLE;
        s_nxt.done = 1'b1; // R24
      end
      tcs_pkg::ST_TRANSMIT, tcs_pkg::ST_SL_SEND: begin
        if (!fifoEmpty) begin // R08
          pop = 1'b1; // R15 R17
          s_nxt.txByte = fifoHead;
          s_nxt.txStrobe = 1'b1;
        end else if (s_r.state == tcs_pkg::ST_TRANSMIT) begin
          s_nxt.state = tcs_pkg::ST_IDLE; // R25
          s_nxt.cmd = tcs_pkg::CMD_IDLE;
          s_nxt.done = 1'b1; // R24
        end else begin
          s_nxt.state = tcs_pkg::ST_SL_RECV; // R17
          s_nxt.launch = 1'b0;
        end
      end
      tcs_pkg::ST_RECEIVE: begin
        if (engineEvent[tcs_pkg::EV_RXEND_BIT]) begin
          s_nxt.state = tcs_pkg::ST_IDLE; // R15
          s_nxt.cmd = tcs_pkg::CMD_IDLE;
          s_nxt.done = 1'b1; // R24
        end
      end
      tcs_pkg::ST_SL_WAIT: begin
        if (s_r.launch) begin
          s_nxt.state = tcs_pkg::ST_SL_SEND; // R08
        end
      end
      tcs_pkg::ST_SL_RECV: begin
        // send-then-listen repeats; only a new code stops it
        if (engineEvent[tcs_pkg::EV_RXEND_BIT]) begin
          s_nxt.state = tcs_pkg::ST_SL_WAIT; // R17
        end
      end
      tcs_pkg::ST_ACTIVATE: begin
        if (engineEvent[tcs_pkg::EV_ACTOK_BIT]) begin
          s_nxt.state = tcs_pkg::ST_SL_WAIT; // R18
          s_nxt.cmd = tcs_pkg::CMD_SENDLISTEN;
        end
      end
      tcs_pkg::ST_AUTH_ARGS: begin
        if (s_r.idx == 5'(tcs_pkg::AUTH_ARGS)) begin
          s_nxt.state = tcs_pkg::ST_AUTH_RUN; // R09
        end else if (!fifoEmpty) begin
          pop = 1'b1; // R19
          s_nxt.txByte = fifoHead;
          s_nxt.txStrobe = 1'b1;
          s_nxt.idx = s_r.idx + 5'h01;
        end
      end
      tcs_pkg::ST_AUTH_RUN: begin
        if (engineEvent[tcs_pkg::EV_AUTHOK_BIT]) begin
          s_nxt.state = tcs_pkg::ST_IDLE; // R19
          s_nxt.cmd = tcs_pkg::CMD_IDLE;
          s_nxt.done = 1'b1; // R24
        end
      end
      default: begin
        s_nxt.state = tcs_pkg::ST_IDLE;
      end
    endcase
    // -----------------------------------------------------------------
    // register writes
    // -----------------------------------------------------------------
    if (wrGo) begin
      s_nxt.awHave = 1'b0;
      s_nxt.wHave = 1'b0;
      s_nxt.bValid = 1'b1;
      s_nxt.bResp = tcs_pkg::RESP_OKAY;
      if (s_r.wStrb[0]) begin
        unique case (s_r.awAddr)
          tcs_pkg::ADDR_CMD: begin
            code = tcs_pkg::tcs_cmd_e'(s_r.wData[3:0]);
            if (s_r.wData[tcs_pkg::CMD_SLEEP_BIT]) begin
              s_nxt.sleepReq = 1'b1; // R01
              s_nxt.sleeping = 1'b1;
            end else if (s_r.sleepReq) begin
              s_nxt.sleepReq = 1'b0; // R03
              s_nxt.wakeCnt = tcs_pkg::WAKE_CNT;
            end
            newCmd = (code != tcs_pkg::CMD_KEEP); // R16
          end
          tcs_pkg::ADDR_FIFO: hostPush = 1'b1; // R07
          tcs_pkg::ADDR_TXCTL: s_nxt.txCtl = s_r.wData[1:0]; // R05
          tcs_pkg::ADDR_FRAME: s_nxt.launch = s_r.wData[tcs_pkg::FRAME_LAUNCH_BIT]; // R08
          tcs_pkg::ADDR_MODE: s_nxt.mode = s_r.wData[1:0];
          tcs_pkg::ADDR_STAT: begin
            // write one clears done; a same-cycle completion wins only when done was clear
            if (s_r.wData[tcs_pkg::STAT_DONE_BIT] && !(s_nxt.done && !s_r.done)) begin
              s_nxt.done = 1'b0;
            end
          end
          default: s_nxt.bResp = tcs_pkg::RESP_SLVERR;
        endcase
      end
    end
    // -----------------------------------------------------------------
    // command start: any new code abandons the running one
    // -----------------------------------------------------------------
    if (newCmd) begin
      s_nxt.idx = '0; // R11
      s_nxt.cmd = code;
      unique case (code)
        tcs_pkg::CMD_CONFIG: s_nxt.state = fifoEmpty ? tcs_pkg::ST_CFG_READ
                                                     : tcs_pkg::ST_CFG_LOAD; // R20 R23
        tcs_pkg::CMD_RANDOM: begin
          s_nxt.state = tcs_pkg::ST_RANDOM; // R13
          s_nxt.idx = 5'(tcs_pkg::PEER_POS - tcs_pkg::RAND_BYTES);
        end
        tcs_pkg::CMD_CHECKSUM: s_nxt.state = s_r.mode[tcs_pkg::MODE_SELFTEST_BIT]
                                             ? tcs_pkg::ST_SELFTEST : tcs_pkg::ST_CHECKSUM; // R14
        tcs_pkg::CMD_TRANSMIT: s_nxt.state = tcs_pkg::ST_TRANSMIT; // R15
        tcs_pkg::CMD_RECEIVE: s_nxt.state = tcs_pkg::ST_RECEIVE; // R15
        tcs_pkg::CMD_SENDLISTEN: s_nxt.state = tcs_pkg::ST_SL_WAIT; // R17
        tcs_pkg::CMD_ACTIVATE: begin
          if (s_r.mode[tcs_pkg::MODE_CARD_BIT]) begin
            s_nxt.state = tcs_pkg::ST_ACTIVATE; // R18
          end else begin
            s_nxt.state = tcs_pkg::ST_IDLE;
            s_nxt.cmd = tcs_pkg::CMD_IDLE;
            s_nxt.done = 1'b1;
          end
        end
        tcs_pkg::CMD_AUTH: s_nxt.state = tcs_pkg::ST_AUTH_ARGS; // R19
        default: begin
          // idle, self reset and unused codes: cancel and finish at once
          s_nxt.state = tcs_pkg::ST_IDLE; // R12
          s_nxt.cmd = tcs_pkg::CMD_IDLE;
          s_nxt.done = (s_r.state != tcs_pkg::ST_IDLE) || s_r.done; // R24
        end
      endcase
    end
    // the FIFO is left alone at command start
    if (hostPush && s_r.count != (FIFO_AWP + 1)'(tcs_pkg::FIFO_DEPTH)) begin // R10
      fifoPush = 1'b1;
      fifoPushData = byteOf(s_r.wData);
    end
    // -----------------------------------------------------------------
    // register reads
    // -----------------------------------------------------------------
    if (axiReq.arvalid && axiRsp.arready) begin
      rdGo = 1'b1;
      s_nxt.rValid = 1'b1;
      s_nxt.rResp = tcs_pkg::RESP_OKAY;
      s_nxt.rData = '0;
      unique case (axiReq.araddr[7:0])
        tcs_pkg::ADDR_CMD: s_nxt.rData = {27'h0, s_r.sleeping, s_r.cmd}; // R03
        tcs_pkg::ADDR_FIFO: begin
          s_nxt.rData = {24'h0, fifoHead};
          pop = pop || !fifoEmpty;
        end
        tcs_pkg::ADDR_LEVEL: s_nxt.rData = {25'h0, s_r.count};
        tcs_pkg::ADDR_STAT: s_nxt.rData = {29'h0, s_r.sleeping, !(&s_r.txCtl), s_r.done};
        tcs_pkg::ADDR_TXCTL: s_nxt.rData = {30'h0, s_r.txCtl};
        tcs_pkg::ADDR_FRAME: s_nxt.rData = {24'h0, s_r.launch, 7'h00};
        tcs_pkg::ADDR_MODE: s_nxt.rData = {30'h0, s_r.mode};
        tcs_pkg::ADDR_PEER: s_nxt.rData = {24'h0, checkByte};
        default: s_nxt.rResp = tcs_pkg::RESP_SLVERR;
      endcase
    end
    // wake sequence: bit drops only when the count runs out
    if (s_r.wakeCnt != '0 && !s_nxt.sleepReq) begin
      s_nxt.wakeCnt = s_r.wakeCnt - 11'h001; // R03
      if (s_r.wakeCnt == 11'h001) begin
        s_nxt.sleeping = 1'b0;
      end
    end
    s_nxt.count = s_r.count + (FIFO_AWP + 1)'(fifoPush) - (FIFO_AWP + 1)'(pop);
    s_nxt.rdPtr = s_r.rdPtr + FIFO_AWP'(pop);
    s_nxt.wrPtr = s_r.wrPtr + FIFO_AWP'(fifoPush);
    if (rdGo && s_r.state == tcs_pkg::ST_IDLE) begin
      s_nxt.state = tcs_pkg::ST_IDLE;
    end
  end

  // -------------------------------------------------------------------
  // state register and storage; power-down freezes and clears nothing, the clock keeps running
  // -------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.cmd <= tcs_pkg::CMD_IDLE;
      s_r.state <= tcs_pkg::ST_IDLE;
      s_r.txCtl <= 2'h0;
      s_r.startCnt <= tcs_pkg::STARTUP_CNT; // R06
      s_r.lfsr <= tcs_pkg::LFSR_SEED;
    end else begin
      s_r <= s_nxt; // R02
    end
  end

  always_ff @(posedge clk) begin
    if (fifoPush) begin
      fifoMem[s_r.wrPtr] <= fifoPushData;
    end
    if (cfgWrite) begin
      cfgMem[s_r.idx] <= cfgWriteData; // R22
    end
  end
endmodule

// file: sim/tcs_sequencer_properties.sv
// Purpose: port-level properties of the command sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every sequencer instance
`timescale 1ns/1ps
module tcs_sequencer_properties (
  input wire logic clk,
  input wire logic rst,
  input wire tcs_pkg::tcs_axi_req_s axiReq,
  input wire tcs_pkg::tcs_axi_rsp_s axiRsp,
  input wire logic [2:0] engineEvent,
  input wire tcs_pkg::tcs_core_s core
);
  // ---
  // helper counters
  // ---
  logic [10:0] upCnt_r;
  logic [10:0] sleepCnt_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      upCnt_r <= 11'h000;
      sleepCnt_r <= 11'h000;
    end else begin
      upCnt_r <= (upCnt_r == 11'h7FF) ? upCnt_r : upCnt_r + 11'h001;
      sleepCnt_r <= !core.softPowerDown ? 11'h000 :
        (sleepCnt_r == 11'h7FF) ? sleepCnt_r : sleepCnt_r + 11'h001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ---
  // properties
  // ---
  property p_bHold;
    axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid;
  endproperty
  a_bHold: assert property (p_bHold) else $error("write answer dropped early");
  property p_rHold;
    axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata);
  endproperty
  a_rHold: assert property (p_rHold) else $error("read answer dropped early");
  property p_slverr;
    axiReq.arvalid && axiRsp.arready && axiReq.araddr > 32'h20
      |=> axiRsp.rvalid && axiRsp.rresp == tcs_pkg::RESP_SLVERR;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped read not refused");
  property p_startup;
    upCnt_r < 11'h400 |-> !axiRsp.arready;
  endproperty
  a_startup: assert property (p_startup) else $error("read taken during startup");
  property p_wake;
    $fell(core.softPowerDown) |-> sleepCnt_r >= 11'h400;
  endproperty
  a_wake: assert property (p_wake) else $error("power-down left too soon");
  property p_sleepField;
    core.softPowerDown |-> !core.fieldOn;
  endproperty
  a_sleepField: assert property (p_sleepField) else $error("field on while asleep");
  property p_crc;
    core.crcStrobe |-> $past(core.checksumActive);
  endproperty
  a_crc: assert property (p_crc) else $error("checksum byte outside command");
  property p_excl;
    $onehot0({core.txActive, core.rxActive, core.checksumActive});
  endproperty
  a_excl: assert property (p_excl) else $error("two commands active");
endmodule

bind tcs_sequencer tcs_sequencer_properties u_props (.clk(clk), .rst(rst), .axiReq(axiReq),
  .axiRsp(axiRsp), .engineEvent(engineEvent), .core(core));

// file: sim/tcs_host_model.sv
// Purpose: host controller reaching the registers over AXI4-Lite
// Assumes: caller enters each task just after a rising edge
// Notes: waits are unbounded; the bench timeout cuts hangs
`timescale 1ns/1ps
module tcs_host_model (
  input wire logic clk,
  output tcs_pkg::tcs_axi_req_s axiReq,
  input wire tcs_pkg::tcs_axi_rsp_s axiRsp
);
  initial axiReq = '0;
  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic awOk;
    logic wOk;
    awOk = 1'b0;
    wOk = 1'b0;
    axiReq.awaddr <= {24'h000000, a};
    axiReq.wdata <= {24'h000000, d};
    axiReq.wstrb <= 4'hF;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    while (!(awOk && wOk)) begin
      @(posedge clk);
      awOk = awOk || (axiReq.awvalid && axiRsp.awready);
      wOk = wOk || (axiReq.wvalid && axiRsp.wready);
      axiReq.awvalid <= !awOk;
      axiReq.wvalid <= !wOk;
    end
    do @(posedge clk); while (axiRsp.bvalid !== 1'b1);
    r = axiRsp.bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    axiReq.araddr <= {24'h000000, a};
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    do @(posedge clk); while (axiRsp.arready !== 1'b1);
    axiReq.arvalid <= 1'b0;
    do @(posedge clk); while (axiRsp.rvalid !== 1'b1);
    d = axiRsp.rdata[7:0];
    r = axiRsp.rresp;
  endtask
endmodule

// file: sim/tb_transceiver_command_sequencer.sv
// Purpose: self-checking bench for the command sequencer
// Assumes: host model drives the lite bus, bench drives engine events
// Notes: queues hold the bytes expected and the bytes seen at the engine strobes
`timescale 1ns/1ps
module tb_transceiver_command_sequencer;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] engineEvent = 3'h0;
  tcs_pkg::tcs_axi_req_s axiReq;
  tcs_pkg::tcs_axi_rsp_s axiRsp;
  tcs_pkg::tcs_core_s core;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [7:0] fifoQ[$];
  logic [7:0] txQ[$];
  logic [7:0] crcQ[$];
  logic [7:0] cfg[25];
  logic [7:0] d;
  logic [1:0] r;
  always #50 clk = ~clk;
  tcs_sequencer dut (.clk(clk), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp),
    .engineEvent(engineEvent), .core(core));
  tcs_host_model host (.clk(clk), .axiReq(axiReq), .axiRsp(axiRsp));
  // ---
  // monitor and timeout
  // ---
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (core.txStrobe === 1'b1) txQ.push_back(core.txByte);
    if (core.crcStrobe === 1'b1) crcQ.push_back(core.crcByte);
    if (cycles > 60000) begin
      n_fail++;
      summarize();
    end
  end
  // ---
  // tasks
  // ---
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic put(input int n);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      fifoQ.push_back(b);
      host.wr(tcs_pkg::ADDR_FIFO, b, r);
    end
  endtask
  task automatic cmpQ(ref logic [7:0] q[$]);
    check(q.size(), fifoQ.size());
    foreach (fifoQ[i]) if (i < q.size()) check(q[i], fifoQ[i]);
    q.delete();
    fifoQ.delete();
  endtask
  task automatic waitDone();
    d = 8'h00;
    for (int i = 0; i < 300 && d[0] !== 1'b1; i++) host.rd(tcs_pkg::ADDR_STAT, d, r);
    check(d[0], 1'b1);
    host.wr(tcs_pkg::ADDR_STAT, 8'h01, r);
  endtask
  // random identifier may rewrite the stored bytes 14..23
  task automatic readBack(input bit skip);
    host.wr(tcs_pkg::ADDR_CMD, 8'h01, r);
    waitDone();
    for (int i = 0; i < tcs_pkg::CFG_BYTES; i++) begin
      host.rd(tcs_pkg::ADDR_FIFO, d, r);
      if (!(skip && i >= 14 && i <= 23)) check(d, cfg[i]);
    end
  endtask
  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ---
  // main sequence
  // ---
  initial begin
    void'($urandom(70));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (1030) @(posedge clk);
    host.rd(8'h24, d, r);
    check(r, tcs_pkg::RESP_SLVERR);
    host.rd(tcs_pkg::ADDR_CMD, d, r);
    check(d, 8'h00);
    for (int i = 0; i < tcs_pkg::CFG_BYTES; i++) begin
      d = (i == 6) ? 8'h01 : (i == 7) ? 8'hFE : 8'($urandom);
      cfg[i] = (i == tcs_pkg::SHORT_ID_POS) ? tcs_pkg::SHORT_ID_FIXED : d;
      host.wr(tcs_pkg::ADDR_FIFO, d, r);
    end
    host.wr(tcs_pkg::ADDR_CMD, 8'h01, r);
    waitDone();
    readBack(1'b0);
    host.rd(tcs_pkg::ADDR_PEER, d, r);
    check(d, cfg[2] ^ cfg[3] ^ cfg[4]);
    host.wr(tcs_pkg::ADDR_CMD, 8'h02, r);
    waitDone();
    readBack(1'b1);
    host.wr(tcs_pkg::ADDR_TXCTL, 8'h01, r);
    check(core.fieldOn, 1'b0);
    host.wr(tcs_pkg::ADDR_TXCTL, 8'h03, r);
    check(core.fieldOn, 1'b1);
    fifoQ.delete();
    txQ.delete();
    put(5);
    host.wr(tcs_pkg::ADDR_CMD, 8'h04, r);
    waitDone();
    cmpQ(txQ);
    put(3);
    host.wr(tcs_pkg::ADDR_CMD, 8'h0C, r);
    repeat (20) @(posedge clk);
    check(txQ.size(), 0);
    host.wr(tcs_pkg::ADDR_FRAME, 8'h80, r);
    for (int i = 0; i < 200 && core.rxActive !== 1'b1; i++) @(posedge clk);
    check(core.rxActive, 1'b1);
    cmpQ(txQ);
    engineEvent <= 3'h1;
    @(posedge clk);
    engineEvent <= 3'h0;
    host.wr(tcs_pkg::ADDR_CMD, 8'h00, r);
    waitDone();
    check(core.rxActive, 1'b0);
    put(4);
    host.wr(tcs_pkg::ADDR_CMD, 8'h03, r);
    put(2);
    host.wr(tcs_pkg::ADDR_CMD, 8'h17, r);
    check(core.softPowerDown, 1'b1);
    check(core.checksumActive, 1'b1);
    check(core.fieldOn, 1'b0);
    host.wr(tcs_pkg::ADDR_CMD, 8'h07, r);
    host.rd(tcs_pkg::ADDR_CMD, d, r);
    check(d[4], 1'b1);
    repeat (1200) @(posedge clk);
    host.rd(tcs_pkg::ADDR_CMD, d, r);
    check(d, 8'h03);
    cmpQ(crcQ);
    host.wr(tcs_pkg::ADDR_CMD, 8'h00, r);
    waitDone();
    // authentication first so that its twelve arguments are in the fifo
    put(12);
    for (int k = 0; k < 3; k++) begin
      host.wr(tcs_pkg::ADDR_CMD, (k == 0) ? 8'h0E : (k == 1) ? 8'h08 : 8'h0D, r);
      for (int i = 0; i < 300 && k == 0 && txQ.size() < 12; i++) @(posedge clk);
      if (k == 0) cmpQ(txQ);
      if (k == 1) check(core.rxActive, 1'b1);
      engineEvent <= (k == 0) ? 3'h2 : (k == 1) ? 3'h1 : 3'h4;
      @(posedge clk);
      engineEvent <= 3'h0;
      waitDone();
    end
    // card mode: activation hands over to send-then-listen
    host.wr(tcs_pkg::ADDR_MODE, 8'h02, r);
    host.wr(tcs_pkg::ADDR_CMD, 8'h0D, r);
    check(core.rxActive, 1'b1);
    engineEvent <= 3'h4;
    @(posedge clk);
    engineEvent <= 3'h0;
    host.rd(tcs_pkg::ADDR_CMD, d, r);
    check(d, 8'h0C);
    summarize();
  end
endmodule
